// ### logic/arf_pkg.sv
// package: constants and types of the converter result buffer
package arf_pkg;

    // ----------------------------------------------------------------
    // widths and depth
    // ----------------------------------------------------------------
    localparam int ARF_ADC_W = 12;
    localparam int ARF_DATA_W = 16;
    localparam int ARF_DEPTH = 512;
    localparam int ARF_ADDR_W = 8;
    localparam int ARF_IRQ_LINES = 6;
    localparam int ARF_DMA_CHANS = 3;
    localparam int ARF_SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ARF_OFF_CTRL = 8'h00;
    localparam logic [7:0] ARF_OFF_STAT = 8'h04;
    localparam logic [7:0] ARF_OFF_DATA = 8'h08;
    localparam logic [7:0] ARF_OFF_INT_CLR = 8'h0C;
    localparam logic [7:0] ARF_OFF_INT_EN = 8'h10;
    localparam logic [7:0] ARF_OFF_INT_STAT = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ARF_CTRL_W = 7;
    localparam int ARF_CTRL_BIP = 0;
    localparam int ARF_CTRL_DMA_EN = 1;
    localparam int ARF_CTRL_CHAN_LSB = 2;
    localparam int ARF_CTRL_IRQ_LSB = 4;
    localparam int ARF_INT_W = 3;
    localparam int ARF_INT_READY = 0;
    localparam int ARF_INT_OVFL = 1;
    localparam int ARF_INT_OVRN = 2;
    localparam int ARF_STAT_CNT_LSB = 16;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] ARF_CTRL_RST = 7'h00;
    localparam logic [2:0] ARF_INT_EN_RST = 3'h0;
    localparam logic [2:0] ARF_INT_STAT_RST = 3'h0;

    // dma byte phase: low byte first, then high byte
    typedef enum logic [0:0] {
        ARF_DMA_LOW = 1'b0,
        ARF_DMA_HIGH = 1'b1
    } arf_dma_phase_t;

endpackage : arf_pkg

// ### logic/arf_mem.sv
// result storage memory with registered read and write bypass
`timescale 1ns/1ps
`default_nettype none
module arf_mem #(
    parameter int W = 16,
    parameter int AW = 9
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata_r
);

    logic [W-1:0] mem [0:(1<<AW)-1];

    // write port
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, a fresh write to the head shows at once
    always_ff @(posedge sys_clk) begin
        if (we && (waddr == raddr)) begin
            rdata_r <= wdata;
        end else begin
            rdata_r <= mem[raddr];
        end
    end

endmodule : arf_mem
`default_nettype wire

// ### logic/arf_top.sv
// converter result buffer: coding, storage, status, interrupts, dma requests
`timescale 1ns/1ps
`default_nettype none
module arf_top
    import arf_pkg::*;
#(
    parameter int DEPTH = ARF_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ARF_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic [ARF_ADC_W-1:0] conv_data,
    input wire logic overrun_evt,
    output logic conv_ack,
    output logic data_present,
    input wire logic dma_ack_pin,
    output logic [ARF_DMA_CHANS-1:0] drq,
    output logic [7:0] dma_data,
    output logic [ARF_IRQ_LINES-1:0] irq_out,
    output logic [ARF_IRQ_LINES-1:0] irq_oe
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if ((DEPTH < 2) || ((1 << AW) != DEPTH)) begin : g_bad_depth
        $error("arf_top: DEPTH must be a power of two of at least 2");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic arf_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : arf_hit

    // recode one converter word and widen it
    function automatic logic [15:0] arf_code(input logic [11:0] raw, input logic bip);
        logic [11:0] c;
        logic ext;
        c = {raw[11] ^ bip, raw[10:0]};
        ext = bip & c[11];
        return {{4{ext}}, c};
    endfunction : arf_code

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [6:0] ctrl_r;
    logic [2:0] int_en_r;
    logic [2:0] int_stat_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic pop_d_r;
    logic [2:0] ack_s_r;
    logic ack_lvl_r;
    logic dma_pend_r;
    arf_dma_phase_t phase_r;
    logic [15:0] head_w;
    logic [15:0] code_w;
    logic [31:0] rd_w;

    wire logic bip = ctrl_r[ARF_CTRL_BIP];
    wire logic dma_en = ctrl_r[ARF_CTRL_DMA_EN];
    wire logic [1:0] dma_chan = ctrl_r[ARF_CTRL_CHAN_LSB +: 2];
    wire logic [2:0] irq_sel = ctrl_r[ARF_CTRL_IRQ_LSB +: 3];
    wire logic avail = count_r != '0;
    wire logic full = count_r == FULL_CNT;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire logic acc = psel & penable;
    wire logic data_rd = acc & ~pwrite & arf_hit(paddr, ARF_OFF_DATA);
    wire logic rd_wait = data_rd & pop_d_r;
    wire logic apb_take = acc & ~pready & ~rd_wait;
    wire logic wr_done = acc & pready & pwrite;
    wire logic apb_pop = apb_take & data_rd & avail;
    wire logic [2:0] int_clr = (wr_done && arf_hit(paddr, ARF_OFF_INT_CLR)) ?
                               pwdata[2:0] : 3'h0;
    wire logic known = arf_hit(paddr, ARF_OFF_CTRL) | arf_hit(paddr, ARF_OFF_STAT) |
                       arf_hit(paddr, ARF_OFF_DATA) | arf_hit(paddr, ARF_OFF_INT_CLR) |
                       arf_hit(paddr, ARF_OFF_INT_EN) | arf_hit(paddr, ARF_OFF_INT_STAT);

    // ----------------------------------------------------------------
    // dma arbitration and push/pop
    // ----------------------------------------------------------------
    wire logic dma_gnt = dma_pend_r & ~pop_d_r & ~apb_take;
    wire logic dma_pop = dma_gnt & avail & (phase_r == ARF_DMA_HIGH);
    wire logic pop = apb_pop | dma_pop;
    wire logic push = conv_done & (~full | pop);
    wire logic ovfl_evt = conv_done & full & ~pop;
    wire logic ack_rise = (ack_s_r[1] == ack_s_r[2]) & ack_s_r[2] & ~ack_lvl_r;

    assign code_w = arf_code(conv_data, bip);

    arf_mem #(
        .W(ARF_DATA_W),
        .AW(AW)
    ) u_mem (
        .sys_clk(sys_clk),
        .we(push),
        .waddr(wr_ptr_r),
        .wdata(code_w),
        .raddr(rd_ptr_r),
        .rdata_r(head_w)
    );

    // occupancy next value
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // buffer pointers and occupancy
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= '0;
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            pop_d_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            pop_d_r <= pop;
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // converter handshake and presence flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conv_ack <= 1'b0;
            data_present <= 1'b0;
        end else begin
            conv_ack <= conv_done;
            data_present <= count_nxt != '0;
        end
    end

    // ----------------------------------------------------------------
    // registers written by software
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_r <= ARF_CTRL_RST;
            int_en_r <= ARF_INT_EN_RST;
        end else if (wr_done) begin
            if (arf_hit(paddr, ARF_OFF_CTRL)) begin
                ctrl_r <= pwdata[ARF_CTRL_W-1:0];
            end
            if (arf_hit(paddr, ARF_OFF_INT_EN)) begin
                int_en_r <= pwdata[ARF_INT_W-1:0];
            end
        end
    end

    // sticky interrupt status, a set beats a clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_stat_r <= ARF_INT_STAT_RST;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) |
                          {overrun_evt, ovfl_evt, avail};
        end
    end

    // read mux
    always_comb begin
        rd_w = 32'h0000_0000;
        if (arf_hit(paddr, ARF_OFF_CTRL)) begin
            rd_w[ARF_CTRL_W-1:0] = ctrl_r;
        end else if (arf_hit(paddr, ARF_OFF_STAT)) begin
            rd_w[ARF_INT_W-1:0] = {int_stat_r[ARF_INT_OVRN], int_stat_r[ARF_INT_OVFL], avail};
            rd_w[ARF_STAT_CNT_LSB +: AW+1] = count_r;
        end else if (arf_hit(paddr, ARF_OFF_DATA)) begin
            rd_w[15:0] = avail ? head_w : 16'h0000;
        end else if (arf_hit(paddr, ARF_OFF_INT_EN)) begin
            rd_w[ARF_INT_W-1:0] = int_en_r;
        end else if (arf_hit(paddr, ARF_OFF_INT_STAT)) begin
            rd_w[ARF_INT_W-1:0] = int_stat_r;
        end
    end

    // ----------------------------------------------------------------
    // apb answer: one wait cycle, two for a data read right after a pop
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_take;
            pslverr <= apb_take & ~known;
            if (apb_take && !pwrite) begin
                prdata <= rd_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // dma acknowledge synchroniser and byte transfer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_s_r <= 3'h0;
            ack_lvl_r <= 1'b0;
        end else begin
            ack_s_r <= {ack_s_r[1:0], dma_ack_pin};
            if (ack_s_r[1] == ack_s_r[2]) begin
                ack_lvl_r <= ack_s_r[2];
            end
        end
    end

    // low byte then high byte, the high byte removes the word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dma_pend_r <= 1'b0;
            phase_r <= ARF_DMA_LOW;
            dma_data <= 8'h00;
        end else if (dma_gnt) begin
            dma_pend_r <= 1'b0;
            if (avail) begin
                unique case (phase_r)
                    ARF_DMA_LOW: begin
                        dma_data <= head_w[7:0];
                        phase_r <= ARF_DMA_HIGH;
                    end
                    ARF_DMA_HIGH: begin
                        dma_data <= head_w[15:8];
                        phase_r <= ARF_DMA_LOW;
                    end
                endcase
            end
        end else if (ack_rise) begin
            dma_pend_r <= 1'b1;
        end
    end

    // request on the selected channel
    for (genvar i = 0; i < ARF_DMA_CHANS; i++) begin : g_drq
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                drq[i] <= 1'b0;
            end else begin
                drq[i] <= dma_en & (dma_chan == 2'(i + 1)) & (count_nxt != '0) &
                          ~ack_lvl_r & ~dma_pend_r & ~ack_rise;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt line select, released while idle
    // ----------------------------------------------------------------
    wire logic irq_act = |(int_stat_r & int_en_r);

    for (genvar i = 0; i < ARF_IRQ_LINES; i++) begin : g_irq
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                irq_out[i] <= 1'b0;
                irq_oe[i] <= 1'b0;
            end else begin
                irq_out[i] <= irq_act & (irq_sel == 3'(i));
                irq_oe[i] <= irq_act & (irq_sel == 3'(i));
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_data_take;
        apb_take && data_rd && !avail && !conv_done;
    endsequence

    AST_APB_ANSWER: assert property (s_apb_setup ##1 (psel && penable) |-> ##[1:2] pready)
        else $error("apb access not answered in time");
    AST_CNT_BOUND: assert property (count_r <= FULL_CNT)
        else $error("buffer occupancy above depth");
    AST_CONV_ACK: assert property (conv_done |=> conv_ack)
        else $error("converter not released after result");
    AST_OVFL_SET: assert property (conv_done && full && !pop |=> int_stat_r[1] && full)
        else $error("overflow not flagged on full buffer");
    AST_PRESENT: assert property (data_present == (count_r != '0))
        else $error("presence flag differs from occupancy");
    AST_UNIPOLAR: assert property (push && !bip |-> code_w == {4'h0, conv_data})
        else $error("unipolar value altered");
    AST_BIPOLAR: assert property (push && bip |-> code_w == {{5{~conv_data[11]}}, conv_data[10:0]})
        else $error("bipolar coding or widening wrong");
    AST_WIDEN: assert property (push |-> code_w[15:12] == 4'h0 || code_w[15:12] == 4'hF)
        else $error("widened value does not start with 0 or F");
    AST_DRQ: assert property (|drq |-> $past(dma_en) && data_present)
        else $error("dma request without data or enable");
    AST_IRQ_LINE: assert property (irq_act |=> irq_out == irq_oe && $onehot0(irq_oe))
        else $error("interrupt line select wrong");
    AST_IRQ_READY: assert property (avail && int_en_r[0] |=> ##1 (irq_sel > 3'd5) || (|irq_oe))
        else $error("ready interrupt not raised");
    AST_OVRN: assert property (overrun_evt |=> int_stat_r[2])
        else $error("overrun flag not set");
    AST_OVFL_HOLD: assert property (int_stat_r[1] && !int_clr[1] |=> int_stat_r[1])
        else $error("overflow flag lost without clear");
    AST_EMPTY_RD: assert property (s_data_take |=> count_r == '0)
        else $error("empty read changed the buffer");

endmodule : arf_top
`default_nettype wire

// ### test/arf_dma_host.sv
// dma controller model: answers requests with acknowledge pulses, gathers bytes
`timescale 1ns/1ps
`default_nettype none
module arf_dma_host (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] drq,
    input wire logic [7:0] dma_data,
    input wire logic [1:0] chan,
    output var logic dma_ack_pin,
    output var logic [15:0] dma_word,
    output var logic [7:0] dma_bytes
);
    // ----------------------------------------------------------------
    // acknowledge loop
    // ----------------------------------------------------------------
    // serve the selected channel, prompt on even bytes and slow on odd
    always begin
        @(posedge sys_clk);
        if (rst) begin
            dma_ack_pin <= 1'b0;
            dma_word <= 16'h0000;
            dma_bytes <= 8'h00;
        end else if (chan != 2'h0 && drq[chan-2'h1] === 1'b1) begin
            repeat (dma_bytes[0] ? 5 : 0) @(posedge sys_clk);
            dma_ack_pin <= 1'b1;
            repeat (8) @(posedge sys_clk);
            dma_word <= {dma_data, dma_word[15:8]}; // low byte first
            dma_bytes <= dma_bytes + 8'h01;
            dma_ack_pin <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    end
endmodule : arf_dma_host
`default_nettype wire

// ### test/arf_top_tb_top.sv
// testbench: result buffer against a queue model
`timescale 1ns/1ps
`default_nettype none
module arf_top_tb_top;
    import arf_pkg::*;
    localparam int DEP = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic conv_done = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic overrun_evt = 1'b0;
    logic [1:0] dma_chan = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, conv_ack, data_present, dma_ack_pin;
    logic [2:0] drq;
    logic [7:0] dma_data, dma_bytes;
    logic [5:0] irq_out, irq_oe;
    logic [15:0] dma_word;
    int n_fail = 0;
    int n_checks = 0;
    int seed = 23;
    logic [15:0] q[$];
    logic [2:0] ist = 3'h0;
    logic bip = 1'b0;
    logic [31:0] rd;
    logic er;

    // ----------------------------------------------------------------
    // clock, design and far side
    // ----------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;

    arf_top #(.DEPTH(DEP)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
        .overrun_evt(overrun_evt), .conv_ack(conv_ack), .data_present(data_present),
        .dma_ack_pin(dma_ack_pin), .drq(drq), .dma_data(dma_data), .irq_out(irq_out),
        .irq_oe(irq_oe));

    arf_dma_host host (.sys_clk(sys_clk), .rst(rst), .drq(drq), .dma_data(dma_data),
        .chan(dma_chan), .dma_ack_pin(dma_ack_pin), .dma_word(dma_word), .dma_bytes(dma_bytes));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (pready !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(32'(er), 32'h0000_0000);
    endtask : rdchk

    function automatic logic [31:0] stat();
        return (32'(q.size()) << 16) | {29'h0, ist[2], ist[1], q.size() != 0};
    endfunction : stat

    // one converter strobe; the model codes it and stores it unless the queue holds DEP words, else sets the overflow flag
    task conv(input logic [11:0] d);
        logic [11:0] c;
        logic took;
        @(posedge sys_clk);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        conv_data <= ~d;
        c = bip ? d ^ 12'h800 : d;
        took = q.size() < DEP;
        if (took)
            q.push_back(bip ? {{4{c[11]}}, c} : {4'h0, c});
        else
            ist[1] = 1'b1;
        ist[0] = 1'b1;
        @(posedge sys_clk);
        if (took)
            chk(32'(conv_ack), 32'h0000_0001);
        chk(32'(data_present), 32'h0000_0001);
    endtask : conv

    task popchk;
        logic [15:0] e;
        e = q.size() != 0 ? q.pop_front() : 16'h0000;
        rdchk(ARF_OFF_DATA, {16'h0000, e});
    endtask : popchk

    task irqchk(input logic [5:0] e);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq_oe), 32'(e));
        chk(32'(irq_out), 32'(e));
    endtask : irqchk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int k;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(ARF_OFF_CTRL, 32'h0000_0000);
        rdchk(ARF_OFF_INT_EN, 32'h0000_0000);
        rdchk(ARF_OFF_INT_STAT, 32'h0000_0000);
        rdchk(ARF_OFF_STAT, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            bip = m[0];
            apb(1'b1, ARF_OFF_CTRL, 32'(m));
            for (int i = 0; i < 6; i++)
                conv(i < 4 ? {i[1], {11{i[0]}}} : 12'($random(seed)));
            rdchk(ARF_OFF_STAT, stat());
            while (q.size() != 0)
                popchk();
            popchk();
            $display("test coding %0d done", m);
        end
        apb(1'b1, ARF_OFF_INT_CLR, 32'h0000_0007);
        ist = 3'h0;
        apb(1'b1, ARF_OFF_INT_EN, 32'h0000_0002);
        apb(1'b1, ARF_OFF_CTRL, 32'h0000_0020);
        bip = 1'b0;
        repeat (DEP + 1) conv(12'($random(seed)));
        rdchk(ARF_OFF_STAT, stat());
        rdchk(ARF_OFF_INT_STAT, {29'h0, ist});
        irqchk(6'h04);
        apb(1'b1, ARF_OFF_INT_EN, 32'h0000_0000);
        irqchk(6'h00);
        apb(1'b1, ARF_OFF_INT_EN, 32'h0000_0002);
        while (q.size() != 0)
            popchk();
        rdchk(ARF_OFF_STAT, stat());
        irqchk(6'h04);
        apb(1'b1, ARF_OFF_INT_CLR, 32'h0000_0002);
        ist[1] = 1'b0;
        rdchk(ARF_OFF_INT_STAT, {29'h0, ist});
        irqchk(6'h00);
        $display("test overflow done");
        @(posedge sys_clk);
        overrun_evt <= 1'b1;
        @(posedge sys_clk);
        overrun_evt <= 1'b0;
        ist[2] = 1'b1;
        apb(1'b0, ARF_OFF_STAT, 32'h0000_0000);
        chk(32'(rd[2]), 32'h0000_0001);
        rdchk(ARF_OFF_INT_STAT, {29'h0, ist});
        apb(1'b1, ARF_OFF_INT_EN, 32'h0000_0005);
        irqchk(6'h04);
        apb(1'b1, ARF_OFF_INT_CLR, 32'h0000_0007);
        apb(1'b1, ARF_OFF_INT_STAT, 32'h0000_0007);
        chk(32'(er), 32'h0000_0000);
        ist = 3'h0;
        rdchk(ARF_OFF_INT_STAT, 32'h0000_0000);
        irqchk(6'h00);
        $display("test overrun done");
        for (int ch = 1; ch < 4; ch++) begin
            dma_chan <= 2'(ch);
            apb(1'b1, ARF_OFF_CTRL, 32'h0000_0002 | 32'(ch << 2));
            conv(12'($random(seed)));
            k = 0;
            while (dma_bytes != 8'(2 * ch) && k < 400) begin
                @(posedge sys_clk);
                k++;
            end
            if (k == 400) begin
                n_fail++;
                print_verdict();
            end
            chk(32'(dma_word), 32'(q.pop_front()));
            rdchk(ARF_OFF_STAT, stat());
            chk(32'(drq), 32'h0000_0000);
        end
        $display("test dma done");
        print_verdict();
    end
endmodule : arf_top_tb_top
`default_nettype wire
